// ### rtl/led_target_pkg.sv
package led_target_pkg;
	// Serial address of the soft-reset call, valid with the write direction only
	localparam logic [6:0] SOFT_RESET_CALL_ADDR = 7'h03;
	// Power-up values of the bus-writable address registers
	localparam logic [7:0] GROUP_BROADCAST_RESET = 8'hE0;
	localparam logic [7:0] SUBGROUP_ONE_RESET = 8'hE2;
	localparam logic [7:0] SUBGROUP_TWO_RESET = 8'hE4;
	localparam logic [7:0] SUBGROUP_THREE_RESET = 8'hE8;
	// Writable part of mode register one: low power, three subgroup enables, broadcast enable
	localparam logic [4:0] MODE_ONE_RESET = 5'h11;
	localparam int SLEEP_BIT = 4;
	localparam int SUBGROUP_ONE_BIT = 3;
	localparam int SUBGROUP_TWO_BIT = 2;
	localparam int SUBGROUP_THREE_BIT = 1;
	localparam int BROADCAST_BIT = 0;
	// Register indices reached through the pointer
	localparam logic [3:0] REG_MODE_ONE = 4'h0;
	localparam logic [3:0] REG_SUBGROUP_ONE = 4'h9;
	localparam logic [3:0] REG_SUBGROUP_TWO = 4'hA;
	localparam logic [3:0] REG_SUBGROUP_THREE = 4'hB;
	localparam logic [3:0] REG_GROUP_BROADCAST = 4'hC;
	localparam logic [3:0] REG_FIRST = 4'h0;
	localparam logic [3:0] REG_LAST = 4'hC;
	localparam logic [3:0] POINTER_RESET = 4'h0;
	localparam logic [2:0] SELECTOR_RESET = 3'h0;
	// Control byte layout
	localparam int POINTER_LSB = 0;
	localparam int POINTER_MSB = 3;
	localparam int SELECTOR_LSB = 5;
	localparam int SELECTOR_MSB = 7;
	localparam int ENABLE_BIT = 2;
	// Increment selector codes and their wrap ranges
	localparam logic [2:0] SEL_ALL = 3'h4;
	localparam logic [2:0] SEL_BRIGHTNESS = 3'h5;
	localparam logic [2:0] SEL_GROUP_CTRL = 3'h6;
	localparam logic [2:0] SEL_BOTH = 3'h7;
	localparam logic [3:0] BRIGHTNESS_FIRST = 4'h2;
	localparam logic [3:0] BRIGHTNESS_LAST = 4'h5;
	localparam logic [3:0] GROUP_CTRL_FIRST = 4'h6;
	localparam logic [3:0] GROUP_CTRL_LAST = 4'h7;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] FIRST_BIT = 3'h0;
	localparam int WRITE_FIFO_DEPTH = 8;

	typedef struct packed {
		logic [3:0] index;
		logic [7:0] data;
	} write_word_type;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_CTRL = 9'h008,
		ST_CTRL_ACK = 9'h010,
		ST_WDATA = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA = 9'h080,
		ST_RACK = 9'h100
	} target_state_type;
endpackage

// ### rtl/led_target_fifo.sv
`timescale 1ns/1ps
module led_target_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic push;
	logic pop;

	// Output word sits in its own register, so the port never sees the array mux
	assign in_ready = (count != FULL_COUNT);
	assign push = in_valid && in_ready;
	assign pop = (count != '0) && (!out_valid || out_ready);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_data <= '0;
			out_valid <= 1'b0;
		end else if (pop) begin
			out_data <= mem[rd_ptr];
			out_valid <= 1'b1;
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule

// ### rtl/led_target.sv
`timescale 1ns/1ps
module led_target
	import led_target_pkg::*;
#(
	parameter logic [6:0] FIXED_ADDRESS = 7'h00,
	parameter logic [6:0] PIN_MASK = 7'h7F,
	parameter int FIFO_DEPTH = led_target_pkg::WRITE_FIFO_DEPTH
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic [6:0] ADDR_PINS,
	output led_target_pkg::write_word_type WR_WORD,
	output logic WR_VALID,
	input wire logic WR_READY,
	output logic [3:0] RD_INDEX,
	input wire logic [7:0] RD_DATA,
	output logic SOFT_RESET_SEEN
);
	import led_target_pkg::*;

	target_state_type state;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [6:0] pins_meta;
	logic [6:0] pins_sync;
	logic scl_prev;
	logic sda_prev;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [2:0] bit_cnt;
	logic byte_full;
	logic [7:0] shreg;
	logic [7:0] tx;
	logic reading;
	logic reset_call;
	logic host_nack;
	logic wr_pend;
	logic sda_oe;
	logic scl_oe;
	logic drive_level;
	logic [3:0] pointer;
	logic [2:0] selector;
	logic [4:0] mode_one;
	logic [7:0] group_addr;
	logic [7:0] sub_one_addr;
	logic [7:0] sub_two_addr;
	logic [7:0] sub_three_addr;
	logic [6:0] regular_addr;
	logic regular_hit;
	logic group_hit;
	logic sub_hit;
	logic reset_hit;
	logic address_hit;
	logic fifo_in_ready;
	logic push;
	logic [7:0] read_byte;
	logic soft_reset_seen;
	write_word_type push_word;

	// Pointer step; a start above the range still runs through the last register
	function automatic logic [3:0] next_pointer(input logic [3:0] ptr, input logic [2:0] sel);
		logic [3:0] first;
		logic [3:0] last;
		first = REG_FIRST;
		last = REG_LAST;
		unique case (sel)
			SEL_BRIGHTNESS: begin
				first = BRIGHTNESS_FIRST;
				last = BRIGHTNESS_LAST;
			end
			SEL_GROUP_CTRL: begin
				first = GROUP_CTRL_FIRST;
				last = GROUP_CTRL_LAST;
			end
			SEL_BOTH: begin
				first = BRIGHTNESS_FIRST;
				last = GROUP_CTRL_LAST;
			end
			default: begin
				first = REG_FIRST;
				last = REG_LAST;
			end
		endcase
		if (!sel[ENABLE_BIT]) begin
			next_pointer = ptr;
		end else if (ptr == last) begin
			next_pointer = first;
		end else if (ptr == REG_LAST) begin
			next_pointer = REG_FIRST;
		end else begin
			next_pointer = ptr + 4'h1;
		end
	endfunction

	// Locally held registers answer here; everything else comes from the user side
	function automatic logic [7:0] read_value(input logic [3:0] ptr);
		unique case (ptr)
			REG_MODE_ONE: read_value = {selector, mode_one};
			REG_SUBGROUP_ONE: read_value = sub_one_addr;
			REG_SUBGROUP_TWO: read_value = sub_two_addr;
			REG_SUBGROUP_THREE: read_value = sub_three_addr;
			REG_GROUP_BROADCAST: read_value = group_addr;
			default: read_value = RD_DATA;
		endcase
	endfunction

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			pins_meta <= 7'h00;
			pins_sync <= 7'h00;
		end else begin
			scl_sync <= {scl_sync[0], SCL_IN};
			sda_sync <= {sda_sync[0], SDA_IN};
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
			pins_meta <= ADDR_PINS;
			pins_sync <= pins_meta;
		end
	end

	assign scl_rise = scl_sync[1] && !scl_prev;
	assign scl_fall = !scl_sync[1] && scl_prev;
	assign start_seen = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
	assign stop_seen = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

	assign regular_addr = (FIXED_ADDRESS & ~PIN_MASK) | (pins_sync & PIN_MASK);
	assign regular_hit = shreg[7:1] == regular_addr;
	// Stored address LSB is not compared
	assign group_hit = mode_one[BROADCAST_BIT] && (shreg[7:1] == group_addr[7:1]);
	assign sub_hit = (mode_one[SUBGROUP_ONE_BIT] && (shreg[7:1] == sub_one_addr[7:1]))
		|| (mode_one[SUBGROUP_TWO_BIT] && (shreg[7:1] == sub_two_addr[7:1]))
		|| (mode_one[SUBGROUP_THREE_BIT] && (shreg[7:1] == sub_three_addr[7:1]));
	assign reset_hit = (shreg[7:1] == SOFT_RESET_CALL_ADDR) && !shreg[0];
	assign address_hit = regular_hit || group_hit || sub_hit || reset_hit;

	// Procedural so that a change on RD_DATA alone also refreshes the byte
	always_comb begin
		read_byte = read_value(pointer);
	end
	assign push = wr_pend && fifo_in_ready;
	assign push_word.index = pointer;
	assign push_word.data = shreg;

	// Link engine; a full write buffer stretches SCL low instead of dropping data
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= ST_IDLE;
			bit_cnt <= FIRST_BIT;
			byte_full <= 1'b0;
			shreg <= 8'h00;
			tx <= 8'h00;
			reading <= 1'b0;
			reset_call <= 1'b0;
			host_nack <= 1'b0;
			wr_pend <= 1'b0;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
			pointer <= POINTER_RESET;
			selector <= SELECTOR_RESET;
		end else if (stop_seen) begin
			state <= ST_IDLE;
			byte_full <= 1'b0;
			wr_pend <= 1'b0;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else if (start_seen) begin
			state <= ST_ADDR;
			bit_cnt <= FIRST_BIT;
			byte_full <= 1'b0;
			wr_pend <= 1'b0;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else if (push) begin
			sda_oe <= 1'b1;
			wr_pend <= 1'b0;
			pointer <= next_pointer(pointer, selector);
			state <= ST_WDATA_ACK;
		end else if (wr_pend) begin
			scl_oe <= 1'b1;
		end else if (scl_oe) begin
			// Clock let go a cycle after the acknowledge, so SDA settles before SCL rises
			scl_oe <= 1'b0;
		end else if (scl_rise) begin
			unique case (state)
				ST_ADDR, ST_CTRL, ST_WDATA: begin
					shreg <= {shreg[6:0], sda_sync[1]};
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == LAST_BIT) begin
						byte_full <= 1'b1;
					end
				end
				ST_RDATA: begin
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == LAST_BIT) begin
						byte_full <= 1'b1;
					end
				end
				ST_RACK: begin
					pointer <= next_pointer(pointer, selector);
					host_nack <= sda_sync[1];
				end
				ST_IDLE, ST_ADDR_ACK, ST_CTRL_ACK, ST_WDATA_ACK: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (state)
				ST_IDLE: begin
				end
				ST_ADDR: begin
					if (byte_full) begin
						byte_full <= 1'b0;
						if (address_hit) begin
							sda_oe <= 1'b1;
							reading <= shreg[0];
							reset_call <= reset_hit;
							state <= ST_ADDR_ACK;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					bit_cnt <= FIRST_BIT;
					if (reading) begin
						tx <= read_byte;
						sda_oe <= !read_byte[7];
						state <= ST_RDATA;
					end else begin
						sda_oe <= 1'b0;
						state <= reset_call ? ST_IDLE : ST_CTRL;
					end
				end
				ST_CTRL: begin
					if (byte_full) begin
						byte_full <= 1'b0;
						if (shreg[POINTER_MSB:POINTER_LSB] <= REG_LAST) begin
							pointer <= shreg[POINTER_MSB:POINTER_LSB];
							selector <= shreg[SELECTOR_MSB:SELECTOR_LSB];
							sda_oe <= 1'b1;
							state <= ST_CTRL_ACK;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_CTRL_ACK, ST_WDATA_ACK: begin
					sda_oe <= 1'b0;
					bit_cnt <= FIRST_BIT;
					state <= ST_WDATA;
				end
				ST_WDATA: begin
					if (byte_full) begin
						byte_full <= 1'b0;
						wr_pend <= 1'b1;
					end
				end
				ST_RDATA: begin
					if (byte_full) begin
						byte_full <= 1'b0;
						sda_oe <= 1'b0;
						state <= ST_RACK;
					end else begin
						tx <= tx << 1;
						sda_oe <= !tx[6];
					end
				end
				ST_RACK: begin
					if (host_nack) begin
						state <= ST_IDLE;
					end else begin
						tx <= read_byte;
						sda_oe <= !read_byte[7];
						bit_cnt <= FIRST_BIT;
						state <= ST_RDATA;
					end
				end
			endcase
		end
	end

	// Address and mode copies live here because matching needs them every byte
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_one <= MODE_ONE_RESET;
			group_addr <= GROUP_BROADCAST_RESET;
			sub_one_addr <= SUBGROUP_ONE_RESET;
			sub_two_addr <= SUBGROUP_TWO_RESET;
			sub_three_addr <= SUBGROUP_THREE_RESET;
		end else if (push) begin
			unique case (pointer)
				REG_MODE_ONE: mode_one <= shreg[SLEEP_BIT:BROADCAST_BIT];
				REG_SUBGROUP_ONE: sub_one_addr <= shreg;
				REG_SUBGROUP_TWO: sub_two_addr <= shreg;
				REG_SUBGROUP_THREE: sub_three_addr <= shreg;
				REG_GROUP_BROADCAST: group_addr <= shreg;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			soft_reset_seen <= 1'b0;
			drive_level <= 1'b0;
		end else begin
			soft_reset_seen <= scl_fall && !stop_seen && !start_seen && !wr_pend
				&& (state == ST_ADDR) && byte_full && reset_hit;
			drive_level <= 1'b0;
		end
	end

	led_target_fifo #(
		.WIDTH($bits(write_word_type)),
		.DEPTH(FIFO_DEPTH)
	) write_fifo (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.in_data(push_word),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.out_data(WR_WORD),
		.out_valid(WR_VALID),
		.out_ready(WR_READY)
	);

	assign SDA_OE = sda_oe;
	assign SDA_OUT = drive_level;
	assign SCL_OE = scl_oe;
	assign SCL_OUT = drive_level;
	assign RD_INDEX = pointer;
	assign SOFT_RESET_SEEN = soft_reset_seen;
endmodule

// ### bench/led_target_asserts.sv
`timescale 1ns/1ps
module led_target_asserts #(
	parameter logic [6:0] FIXED_ADDRESS = 7'h00,
	parameter logic [6:0] PIN_MASK = 7'h7F,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic SCL_IN,
	input wire logic SCL_OUT,
	input wire logic SCL_OE,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic [6:0] ADDR_PINS,
	input wire led_target_pkg::write_word_type WR_WORD,
	input wire logic WR_VALID,
	input wire logic WR_READY,
	input wire logic [3:0] RD_INDEX,
	input wire logic [7:0] RD_DATA,
	input wire logic SOFT_RESET_SEEN
);
	import led_target_pkg::*;
	default clocking dc @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	logic [3:0] ack_age;
	// Reset pulse may land just before or just after its acknowledge
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack_age <= 4'hF;
		end else if (SDA_OE) begin
			ack_age <= 4'h0;
		end else if (ack_age != 4'hF) begin
			ack_age <= ack_age + 4'h1;
		end
	end
	property p_rst_quiet;
		$rose(RST_N) |-> (!SDA_OE && !SCL_OE && !WR_VALID && RD_INDEX == POINTER_RESET) [*3];
	endproperty
	property p_sr_pulse;
		SOFT_RESET_SEEN |=> !SOFT_RESET_SEEN;
	endproperty
	property p_sr_ack;
		SOFT_RESET_SEEN |-> (ack_age < 4'hC) or (##[0:12] SDA_OE);
	endproperty
	property p_wr_hold;
		WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_WORD);
	endproperty
	property p_wr_index;
		WR_VALID |-> WR_WORD.index <= REG_LAST;
	endproperty
	property p_ptr_range;
		RD_INDEX <= REG_LAST;
	endproperty
	property p_sda_low_clock;
		$changed(SDA_OE) |-> !SCL_IN;
	endproperty
	property p_stretch_full;
		$rose(SCL_OE) |-> WR_VALID;
	endproperty
	property p_stretch_ack;
		$fell(SCL_OE) |-> SDA_OE;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("bus active after reset");
	a_sr_pulse: assert property (p_sr_pulse) else $error("reset pulse too long");
	a_sr_ack: assert property (p_sr_ack) else $error("reset pulse without ack");
	a_wr_hold: assert property (p_wr_hold) else $error("write word dropped");
	a_wr_index: assert property (p_wr_index) else $error("write index reserved");
	a_ptr_range: assert property (p_ptr_range) else $error("pointer out of range");
	a_sda_low_clock: assert property (p_sda_low_clock) else $error("data moved, clock high");
	a_stretch_full: assert property (p_stretch_full) else $error("stretch, buffer not full");
	a_stretch_ack: assert property (p_stretch_ack) else $error("stretch end without ack");
	c_soft_reset: cover property (SOFT_RESET_SEEN);
	c_stretch: cover property ($rose(SCL_OE));
	c_word: cover property (WR_VALID && WR_READY);
endmodule
bind led_target led_target_asserts #(
	.FIXED_ADDRESS(FIXED_ADDRESS),
	.PIN_MASK(PIN_MASK),
	.FIFO_DEPTH(FIFO_DEPTH)
) u_led_target_asserts (
	.REF_CLK(REF_CLK),
	.RST_N(RST_N),
	.SCL_IN(SCL_IN),
	.SCL_OUT(SCL_OUT),
	.SCL_OE(SCL_OE),
	.SDA_IN(SDA_IN),
	.SDA_OUT(SDA_OUT),
	.SDA_OE(SDA_OE),
	.ADDR_PINS(ADDR_PINS),
	.WR_WORD(WR_WORD),
	.WR_VALID(WR_VALID),
	.WR_READY(WR_READY),
	.RD_INDEX(RD_INDEX),
	.RD_DATA(RD_DATA),
	.SOFT_RESET_SEEN(SOFT_RESET_SEEN)
);

// ### bench/bus_ctl.sv
`timescale 1ns/1ps
module bus_ctl (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_drv,
	output logic sda_drv,
	output logic stuck
);
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
		stuck = 1'b0;
	end
	task automatic q();
		repeat (2) @(posedge clk);
	endtask
	// Eight clocks a bit, five low so a late acknowledge settles before SCL rises
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		q();
		@(posedge clk);
		scl_drv <= 1'b1;
		q();
		for (int n = 0; n < 1000 && !scl; n++) @(posedge clk);
		if (!scl) stuck <= 1'b1;
		@(posedge clk);
		r = sda;
		scl_drv <= 1'b0;
		q();
	endtask
	task automatic start();
		sda_drv <= 1'b1;
		q();
		scl_drv <= 1'b1;
		q();
		sda_drv <= 1'b0;
		q();
		scl_drv <= 1'b0;
		q();
	endtask
	task automatic stop();
		sda_drv <= 1'b0;
		q();
		scl_drv <= 1'b1;
		q();
		sda_drv <= 1'b1;
		q();
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import led_target_pkg::*;
	localparam logic [6:0] MY_ADDR = 7'h15;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] addr_pins = MY_ADDR;
	logic wr_ready = 1'b1;
	logic [7:0] rd_data = 8'h00;
	logic stretched = 1'b0;
	logic sr_hit = 1'b0;
	logic scl_oe, sda_oe, scl_drv, sda_drv, scl_out, sda_out, wr_valid, sr_seen, stuck, ack;
	logic [3:0] rd_index;
	logic [7:0] rdat;
	write_word_type wr_word;
	write_word_type got_q[$];
	write_word_type exp_q[$];
	int miscompares = 0;
	int checks = 0;
	logic [7:0] sub_codes[6] = '{8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE8, 8'hE9};
	logic [7:0] ctrls[6] = '{8'h03, 8'h88, 8'hA4, 8'hC7, 8'hE6, 8'hAA};
	int cnts[6] = '{3, 7, 4, 3, 4, 6};
	wire scl = scl_drv & ~scl_oe;
	wire sda = sda_drv & ~sda_oe;
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		rd_data <= {4'h5, rd_index};
		if (wr_valid && wr_ready) got_q.push_back(wr_word);
		if (scl_oe) stretched <= 1'b1;
		if (sr_seen) sr_hit <= 1'b1;
	end
	led_target u_led_target (.REF_CLK(ref_clk), .RST_N(rst_n), .SCL_IN(scl), .SCL_OUT(scl_out),
		.SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_PINS(addr_pins),
		.WR_WORD(wr_word), .WR_VALID(wr_valid), .WR_READY(wr_ready), .RD_INDEX(rd_index),
		.RD_DATA(rd_data), .SOFT_RESET_SEEN(sr_seen));
	bus_ctl u_bus_ctl (.clk(ref_clk), .scl(scl), .sda(sda), .scl_drv(scl_drv),
		.sda_drv(sda_drv), .stuck(stuck));
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] wdata(input logic [3:0] p);
		case (p)
			4'h0: return 8'h09;
			4'h9: return 8'hE2;
			4'hA: return 8'hE4;
			4'hB: return 8'hE8;
			4'hC: return 8'hE0;
			default: return {4'hA, p};
		endcase
	endfunction
	function automatic logic [3:0] next_ptr(input logic [2:0] sel, input logic [3:0] p);
		logic [3:0] first;
		logic [3:0] last;
		first = (sel[1:0] == 2'h2) ? 4'h6 : ((sel[1:0] == 2'h0) ? 4'h0 : 4'h2);
		last = sel[1] ? 4'h7 : (sel[0] ? 4'h5 : 4'hC);
		if (!sel[2]) return p;
		if (p == last) return first;
		if (p == 4'hC) return 4'h0;
		return p + 4'h1;
	endfunction
	task automatic addr_try(input logic [7:0] a, input logic exp);
		u_bus_ctl.start();
		u_bus_ctl.put(a, ack);
		check("addr ack", 12'(ack), 12'(exp));
		if (ack && a[0]) u_bus_ctl.get(1'b1, rdat);
		u_bus_ctl.stop();
	endtask
	task automatic burst(input logic [7:0] ctrl, input int n);
		logic [3:0] p;
		p = ctrl[3:0];
		u_bus_ctl.start();
		u_bus_ctl.put({MY_ADDR, 1'b0}, ack);
		u_bus_ctl.put(ctrl, ack);
		check("ctrl ack", 12'(ack), 12'h001);
		for (int i = 0; i < n; i++) begin
			u_bus_ctl.put(wdata(p), ack);
			check("data ack", 12'(ack), 12'h001);
			exp_q.push_back({p, wdata(p)});
			p = next_ptr(ctrl[7:5], p);
		end
		u_bus_ctl.stop();
	endtask
	always @(posedge stuck) begin
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		check("reset out", {4'h0, sda_oe, scl_oe, wr_valid, sr_seen, rd_index}, 12'h0);
		addr_try(8'hE0, 1'b1);
		addr_try(8'hE1, 1'b1);
		check("mode read", 12'(rdat), 12'h011);
		foreach (sub_codes[i]) addr_try(sub_codes[i], 1'b0);
		addr_try(8'h07, 1'b0);
		check("reset call", 12'(sr_hit), 12'h000);
		addr_try(8'h06, 1'b1);
		check("reset call", 12'(sr_hit), 12'h001);
		addr_pins <= 7'h2A;
		repeat (4) @(posedge ref_clk);
		addr_try(8'h54, 1'b1);
		addr_try({MY_ADDR, 1'b0}, 1'b0);
		addr_pins <= MY_ADDR;
		repeat (4) @(posedge ref_clk);
		for (int i = 13; i < 16; i++) begin
			u_bus_ctl.start();
			u_bus_ctl.put(8'hE0, ack);
			u_bus_ctl.put({4'h8, i[3:0]}, ack);
			check("ctrl nack", 12'(ack), 12'h000);
			u_bus_ctl.stop();
		end
		for (int i = 0; i < 6; i++) burst(ctrls[i], cnts[i]);
		addr_try(8'hE2, 1'b1);
		u_bus_ctl.start();
		u_bus_ctl.put({MY_ADDR, 1'b0}, ack);
		u_bus_ctl.put({4'h0, REG_SUBGROUP_ONE}, ack);
		u_bus_ctl.put(8'hE3, ack);
		check("sub write ack", 12'(ack), 12'h001);
		u_bus_ctl.stop();
		exp_q.push_back({REG_SUBGROUP_ONE, 8'hE3});
		addr_try(8'hE2, 1'b1);
		addr_try(8'hE3, 1'b1);
		u_bus_ctl.start();
		u_bus_ctl.put({MY_ADDR, 1'b0}, ack);
		u_bus_ctl.put(8'h80, ack);
		u_bus_ctl.start();
		u_bus_ctl.put({MY_ADDR, 1'b1}, ack);
		u_bus_ctl.get(1'b0, rdat);
		check("read mode", 12'(rdat), 12'h089);
		u_bus_ctl.get(1'b1, rdat);
		check("read next", 12'(rdat), 12'h051);
		u_bus_ctl.stop();
		// Sink stalls so the buffer fills and the target holds the clock
		wr_ready <= 1'b0;
		fork
			burst(8'h03, 12);
			begin
				repeat (1400) @(posedge ref_clk);
				wr_ready <= 1'b1;
			end
		join
		check("stretched", 12'(stretched), 12'h001);
		for (int n = 0; n < 300 && got_q.size() < exp_q.size(); n++) @(posedge ref_clk);
		check("word count", 12'(got_q.size()), 12'(exp_q.size()));
		foreach (exp_q[i]) check("word", got_q[i], exp_q[i]);
		give_verdict();
	end
endmodule
